// ---- verilog/dbrc_core.sv ----
// debug run control: halt, resume, block memory and cpu register reads
`timescale 1ns/1ps
`default_nettype none
`include "dbrc_consts.svh"

module dbrc_core
  import dbrc_pkg::*;
#(
  parameter int ADDR_W  = 24,
  parameter int ACK_LEN = `DBRC_ACK_CYCLES
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  // decoded commands from the serial front end
  input  wire logic         cmdValid,
  input  wire dbrc_cmd_type cmdCode,
  input  wire logic [1:0]   cmdSize,
  input  wire logic         cmdWithStatus,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [31:0]  cmdWdata,
  input  wire logic         syncReq,
  output logic              cmdReady,
  // control and status bits
  input  wire logic         debugEnable,
  input  wire logic         ackEnable,
  input  wire logic         clearIllegal,
  output logic              debugActive,
  output logic              noResponse,
  output logic              illegalFlag,
  // cpu side
  input  wire logic         cpuInstrDone,
  input  wire logic         cpuWaitMode,
  input  wire logic         cpuStopMode,
  input  wire logic         breakHalt,
  output logic              cpuResume,
  // memory bus
  output logic              memReq,
  output logic              memWrite,
  output logic [ADDR_W-1:0] memAddr,
  output logic [1:0]        memSize,
  output logic [31:0]       memWdata,
  input  wire logic         memDone,
  input  wire logic         memAbort,
  input  wire logic [31:0]  memRdata,
  // cpu register file
  output logic              regReq,
  input  wire logic         regDone,
  input  wire logic [31:0]  regRdata,
  input  wire logic [3:0]   regByteValid,
  // answer to the serial front end
  output logic              respValid,
  output logic              respHasData,
  output logic              respHasStatus,
  output logic              respStatusFirst,
  output logic [31:0]       respData,
  output logic [7:0]        respStatus,
  output logic              illegalResp,
  output logic              ackPulse
);

  dbrc_state_type    state;
  dbrc_state_type    next_state;
  dbrc_prev_type     prevKind;
  dbrc_prev_type     next_prevKind;
  logic              haltPending;
  logic              next_haltPending;
  logic              next_debugActive;
  logic              next_illegalFlag;
  logic [ADDR_W-1:0] tempAddr;
  logic [ADDR_W-1:0] next_tempAddr;
  logic [ADDR_W-1:0] step;
  logic              opStatus;
  logic              next_opStatus;
  logic              sendAfter;
  logic              next_sendAfter;
  logic              ackTrig;
  logic              next_ackTrig;
  logic              ackBusy;
  logic              next_cmdReady;
  logic              next_noResponse;
  logic              next_cpuResume;
  logic              next_memReq;
  logic              next_memWrite;
  logic [ADDR_W-1:0] next_memAddr;
  logic [1:0]        next_memSize;
  logic [31:0]       next_memWdata;
  logic              next_regReq;
  logic              next_respValid;
  logic              next_respHasData;
  logic              next_respHasStatus;
  logic              next_respStatusFirst;
  logic [31:0]       next_respData;
  logic [7:0]        next_respStatus;
  logic              next_illegalResp;
  logic [31:0]       regMasked;
  logic              setIllegal;

  ////////////////////////////////////////////////////////////////////////////
  // operand size to address step
  always_comb
  begin
    unique case (cmdSize)
      `DBRC_SZ_BYTE: step = ADDR_W'(`DBRC_STEP_BYTE);
      `DBRC_SZ_WORD: step = ADDR_W'(`DBRC_STEP_WORD);
      default:       step = ADDR_W'(`DBRC_STEP_LONG);
    endcase
  end

  // unimplemented register bytes read as zero
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_mask
      assign regMasked[8*b +: 8] = regByteValid[b] ?
                                   regRdata[8*b +: 8] : 8'h00;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and debug mode next state
  always_comb
  begin
    next_state           = state;
    next_prevKind        = prevKind;
    next_haltPending     = haltPending;
    next_debugActive     = debugActive;
    next_tempAddr        = tempAddr;
    next_opStatus        = opStatus;
    next_sendAfter       = sendAfter;
    next_ackTrig         = 1'b0;
    next_cpuResume       = 1'b0;
    next_memReq          = memReq;
    next_memWrite        = memWrite;
    next_memAddr         = memAddr;
    next_memSize         = memSize;
    next_memWdata        = memWdata;
    next_regReq          = regReq;
    next_respValid       = 1'b0;
    next_respHasData     = respHasData;
    next_respHasStatus   = respHasStatus;
    next_respStatusFirst = respStatusFirst;
    next_respData        = respData;
    next_respStatus      = respStatus;
    next_illegalResp     = 1'b0;
    setIllegal           = 1'b0;

    // halt completes only at an instruction boundary; wait never gives one
    if (haltPending && cpuInstrDone)
    begin
      next_haltPending = 1'b0;
      next_debugActive = 1'b1;
    end
    if (breakHalt && debugEnable)
      next_debugActive = 1'b1;

    unique case (state)
      DBRC_IDLE:
      begin
        // commands are taken while a halt is pending, too
        if (cmdValid)
        begin
          next_prevKind = DBRC_PREV_OTHER;
          unique case (cmdCode)
            DBRC_CMD_NOP:
              next_prevKind = DBRC_PREV_NEUTRAL;      // pointer untouched
            DBRC_CMD_HALT:
              if (debugEnable && !debugActive)
                next_haltPending = 1'b1;
            DBRC_CMD_RESUME,
            DBRC_CMD_RESUME_UNTIL:
              if (!debugActive)
                setIllegal = 1'b1;
              else
              begin
                next_debugActive = 1'b0;
                next_cpuResume   = 1'b1;
                next_sendAfter   = 1'b0;
                if (ackEnable && cmdCode == DBRC_CMD_RESUME_UNTIL)
                  next_state = DBRC_UNTIL;
                else if (ackEnable)
                begin
                  next_ackTrig = 1'b1;
                  next_state   = DBRC_ACK;
                end
              end
            DBRC_CMD_READ_MEM:
            begin
              // single read done elsewhere; pointer steps past it
              next_tempAddr = cmdAddr + step;
              next_prevKind = DBRC_PREV_READ;
            end
            DBRC_CMD_WRITE_MEM:
            begin
              next_tempAddr = cmdAddr + step;
              next_prevKind = DBRC_PREV_WRITE;
            end
            DBRC_CMD_BLOCK_READ,
            DBRC_CMD_BLOCK_WRITE:
              if ((cmdCode == DBRC_CMD_BLOCK_READ &&
                   prevKind == DBRC_PREV_WRITE) ||
                  (cmdCode == DBRC_CMD_BLOCK_WRITE &&
                   prevKind == DBRC_PREV_READ) ||
                  prevKind == DBRC_PREV_OTHER)
                setIllegal = 1'b1;
              else
              begin
                next_memReq   = 1'b1;
                next_memWrite = (cmdCode == DBRC_CMD_BLOCK_WRITE);
                next_memAddr  = tempAddr;
                next_memSize  = cmdSize;
                next_memWdata = cmdWdata;
                next_opStatus = cmdWithStatus;
                next_prevKind = (cmdCode == DBRC_CMD_BLOCK_READ) ?
                                DBRC_PREV_READ : DBRC_PREV_WRITE;
                next_tempAddr = tempAddr + step;
                next_state    = DBRC_MEM;
              end
            DBRC_CMD_REG_READ:
              if (!debugActive)
                setIllegal = 1'b1;
              else
              begin
                next_regReq = 1'b1;
                next_state  = DBRC_REG;
              end
            default:
              next_prevKind = DBRC_PREV_OTHER;
          endcase
          next_illegalResp = setIllegal;
        end
      end

      DBRC_MEM:
        if (memDone || memAbort)
        begin
          next_memReq          = 1'b0;
          next_respHasData     = !memWrite;
          next_respData        = memWrite ? `DBRC_DATA_RESET : memRdata;
          next_respHasStatus   = opStatus;
          next_respStatusFirst = !memWrite;
          // written state sampled after the access has finished
          next_respStatus      = '0;
          next_respStatus[`DBRC_ST_ENABLE]  = debugEnable;
          next_respStatus[`DBRC_ST_ACTIVE]  = next_debugActive;
          next_respStatus[`DBRC_ST_WAIT]    = cpuWaitMode;
          next_respStatus[`DBRC_ST_NO_RESPONSE_FLAG]  = next_noResponse;
          next_respStatus[`DBRC_ST_ILLEGAL] = illegalFlag;
          if (ackEnable)
          begin
            next_ackTrig   = 1'b1;
            next_sendAfter = !memWrite || opStatus;
            next_state     = DBRC_ACK;
          end
          else
          begin
            next_respValid = !memWrite || opStatus;
            next_state     = DBRC_IDLE;
          end
        end

      DBRC_REG:
        if (regDone)
        begin
          next_regReq          = 1'b0;
          next_respHasData     = 1'b1;
          next_respHasStatus   = 1'b0;
          next_respStatusFirst = 1'b0;
          next_respData        = regMasked;
          if (ackEnable)
          begin
            next_ackTrig   = 1'b1;
            next_sendAfter = 1'b1;
            next_state     = DBRC_ACK;
          end
          else
          begin
            next_respValid = 1'b1;
            next_state     = DBRC_IDLE;
          end
        end

      DBRC_ACK:
        // answer only after the pulse ends
        if (!ackTrig && !ackBusy)
        begin
          next_respValid = sendAfter;
          next_state     = DBRC_IDLE;
        end

      DBRC_UNTIL:
        // no timeout here: only re-entry or a sync ends the wait
        if (debugActive)
        begin
          next_ackTrig   = 1'b1;
          next_sendAfter = 1'b0;
          next_state     = DBRC_ACK;
        end
    endcase

    // sync drops any access, wait or answer in flight but keeps a pending halt, acts as neutral predecessor
    if (syncReq)
    begin
      next_state     = DBRC_IDLE;
      next_prevKind  = DBRC_PREV_NEUTRAL;
      next_memReq    = 1'b0;
      next_regReq    = 1'b0;
      next_ackTrig   = 1'b0;
      next_respValid = 1'b0;
    end
  end

  // flag outputs; a set in the clearing cycle survives
  always_comb
  begin
    next_illegalFlag = (illegalFlag && !clearIllegal) || setIllegal;
    next_noResponse  = next_haltPending &&
                       (cpuWaitMode || cpuStopMode);
    next_cmdReady    = (next_state == DBRC_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // register every piece of state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state           <= DBRC_IDLE;
      prevKind        <= DBRC_PREV_OTHER;
      haltPending     <= 1'b0;
      debugActive     <= 1'b0;
      illegalFlag     <= 1'b0;
      noResponse      <= 1'b0;
      cmdReady        <= 1'b0;
      tempAddr        <= ADDR_W'(`DBRC_ADDR_RESET);
      opStatus        <= 1'b0;
      sendAfter       <= 1'b0;
      ackTrig         <= 1'b0;
      cpuResume       <= 1'b0;
      memReq          <= 1'b0;
      memWrite        <= 1'b0;
      memAddr         <= ADDR_W'(`DBRC_ADDR_RESET);
      memSize         <= `DBRC_SZ_BYTE;
      memWdata        <= `DBRC_DATA_RESET;
      regReq          <= 1'b0;
      respValid       <= 1'b0;
      respHasData     <= 1'b0;
      respHasStatus   <= 1'b0;
      respStatusFirst <= 1'b0;
      respData        <= `DBRC_DATA_RESET;
      respStatus      <= `DBRC_BYTE_RESET;
      illegalResp     <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      prevKind        <= next_prevKind;
      haltPending     <= next_haltPending;
      debugActive     <= next_debugActive;
      illegalFlag     <= next_illegalFlag;
      noResponse      <= next_noResponse;
      cmdReady        <= next_cmdReady;
      tempAddr        <= next_tempAddr;
      opStatus        <= next_opStatus;
      sendAfter       <= next_sendAfter;
      ackTrig         <= next_ackTrig;
      cpuResume       <= next_cpuResume;
      memReq          <= next_memReq;
      memWrite        <= next_memWrite;
      memAddr         <= next_memAddr;
      memSize         <= next_memSize;
      memWdata        <= next_memWdata;
      regReq          <= next_regReq;
      respValid       <= next_respValid;
      respHasData     <= next_respHasData;
      respHasStatus   <= next_respHasStatus;
      respStatusFirst <= next_respStatusFirst;
      respData        <= next_respData;
      respStatus      <= next_respStatus;
      illegalResp     <= next_illegalResp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge pulse on the line, cut short by sync
  dbrc_pulse_gen
  #(
    .LEN   (ACK_LEN)
  )
  u_ack
  (
    .clk   (clk),
    .rst   (rst),
    .start (ackTrig),
    .abort (syncReq),
    .pulse (ackPulse)
  );

  assign ackBusy = ackPulse;

endmodule
`default_nettype wire

// ---- verilog/dbrc_consts.svh ----
// constants of the debug run control block
`ifndef DBRC_CONSTS_SVH
`define DBRC_CONSTS_SVH

// operand size field codes
`define DBRC_SZ_BYTE      2'h0
`define DBRC_SZ_WORD      2'h1
`define DBRC_SZ_LONG      2'h2

// address steps per operand size, in bytes
`define DBRC_STEP_BYTE    24'h00_0001
`define DBRC_STEP_WORD    24'h00_0002
`define DBRC_STEP_LONG    24'h00_0004

// status byte low, bit positions
`define DBRC_ST_ENABLE    7
`define DBRC_ST_ACTIVE    6
`define DBRC_ST_WAIT      3
`define DBRC_ST_NO_RESPONSE_FLAG    2
`define DBRC_ST_ILLEGAL   1

// reset values
`define DBRC_ADDR_RESET   24'h00_0000
`define DBRC_DATA_RESET   32'h0000_0000
`define DBRC_BYTE_RESET   8'h00

// acknowledge pulse length in serial interface clock cycles
`define DBRC_ACK_CYCLES   16

`endif

// ---- verilog/dbrc_pkg.sv ----
// types shared by the debug run control and block access block
package dbrc_pkg;

  // decoded command from the serial front end
  typedef enum logic [3:0] {
    DBRC_CMD_NOP,
    DBRC_CMD_HALT,
    DBRC_CMD_RESUME,
    DBRC_CMD_RESUME_UNTIL,
    DBRC_CMD_READ_MEM,
    DBRC_CMD_WRITE_MEM,
    DBRC_CMD_BLOCK_READ,
    DBRC_CMD_BLOCK_WRITE,
    DBRC_CMD_REG_READ,
    DBRC_CMD_OTHER
  } dbrc_cmd_type;

  // what the previous command allows next
  typedef enum logic [1:0] {
    DBRC_PREV_NEUTRAL,
    DBRC_PREV_READ,
    DBRC_PREV_WRITE,
    DBRC_PREV_OTHER
  } dbrc_prev_type;

  typedef enum logic [2:0] {
    DBRC_IDLE,
    DBRC_MEM,
    DBRC_REG,
    DBRC_ACK,
    DBRC_UNTIL
  } dbrc_state_type;

endpackage

// ---- verilog/dbrc_pulse_gen.sv ----
// acknowledge pulse generator, cut short by sync
`timescale 1ns/1ps
`default_nettype none
`include "dbrc_consts.svh"

module dbrc_pulse_gen
#(
  parameter int LEN = `DBRC_ACK_CYCLES
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic abort,
  output logic      pulse
);

  localparam int CW = $clog2(LEN + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // count down the pulse; abort wins so a sync always drops the line low
  always_comb
  begin
    next_count = count;
    if (abort)
      next_count = '0;
    else if (start)
      next_count = CW'(LEN);
    else if (count != '0)
      next_count = count - CW'(1);
    next_pulse = (next_count != '0);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      pulse <= 1'b0;
    end
    else
    begin
      count <= next_count;
      pulse <= next_pulse;
    end
  end

endmodule
`default_nettype wire

// ---- dv/dbrc_core_assertions.sv ----
// port checks of the debug run control block
`timescale 1ns/1ps
`default_nettype none

module dbrc_core_assertions
  import dbrc_pkg::*;
#(
  parameter int ADDR_W  = 24,
  parameter int ACK_LEN = 16
)
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              cmdValid,
  input wire logic              cmdReady,
  input wire dbrc_cmd_type      cmdCode,
  input wire logic [1:0]        cmdSize,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic              debugEnable,
  input wire logic              ackEnable,
  input wire logic              debugActive,
  input wire logic              noResponse,
  input wire logic              illegalResp,
  input wire logic              illegalFlag,
  input wire logic              cpuInstrDone,
  input wire logic              cpuWaitMode,
  input wire logic              cpuResume,
  input wire logic              memReq,
  input wire logic              memWrite,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic [1:0]        memSize,
  input wire logic              memDone,
  input wire logic              memAbort,
  input wire logic              regReq,
  input wire logic              respValid,
  input wire logic              respHasData,
  input wire logic              respHasStatus,
  input wire logic              respStatusFirst,
  input wire logic              ackPulse
);
  logic              taken;
  logic              blk;
  logic [ADDR_W-1:0] ptr;
  logic [7:0]        ackCnt;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign taken = cmdValid && cmdReady;

  function automatic logic [ADDR_W-1:0] step(input logic [1:0] s);
    return (s == 2'h0) ? ADDR_W'(1) : ((s == 2'h1) ? ADDR_W'(2) : ADDR_W'(4));
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // expected pointer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ptr    <= '0;
      blk    <= 1'b0;
      ackCnt <= 8'h00;
    end
    else
    begin
      if (taken)
        blk <= cmdCode inside {DBRC_CMD_BLOCK_READ, DBRC_CMD_BLOCK_WRITE};
      if (taken && cmdCode inside {DBRC_CMD_READ_MEM, DBRC_CMD_WRITE_MEM})
        ptr <= cmdAddr + step(cmdSize);
      else if ($rose(memReq))
        ptr <= memAddr + step(memSize);
      ackCnt <= ackPulse ? ackCnt + 8'h01 : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  sequence s_halt;
    taken && cmdCode == DBRC_CMD_HALT && debugEnable && !debugActive;
  endsequence
  sequence s_wr_end;
    memReq && memWrite && (memDone || memAbort);
  endsequence
  property p_halt_off;
    !debugEnable && !debugActive |=> !debugActive;
  endproperty
  a_halt_off: assert property (p_halt_off)
    else $error("entered while disabled");
  property p_halt_on;
    (s_halt and !cpuWaitMode) ##1 cpuInstrDone |=> debugActive;
  endproperty
  a_halt_on: assert property (p_halt_on)
    else $error("halt missed");
  property p_halt_wait;
    s_halt and cpuWaitMode |-> ##2 (noResponse && !debugActive);
  endproperty
  a_halt_wait: assert property (p_halt_wait)
    else $error("pending flags");
  property p_illegal;
    taken && !debugActive && cmdCode inside {DBRC_CMD_RESUME,
      DBRC_CMD_RESUME_UNTIL, DBRC_CMD_REG_READ}
      |=> illegalResp && !regReq ##1 illegalFlag;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("not refused");
  property p_ptr;
    $rose(memReq) && blk |-> memAddr == ptr;
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("bad address");
  property p_rd_status;
    respValid && respHasData && respHasStatus |-> respStatusFirst;
  endproperty
  a_rd_status: assert property (p_rd_status)
    else $error("status not first");
  property p_wr_status;
    respValid && respHasStatus && !respHasData |-> !respStatusFirst;
  endproperty
  a_wr_status: assert property (p_wr_status)
    else $error("status not last");
  property p_rd_ack;
    $rose(respValid) && respHasData && ackEnable
      |-> $past(ackPulse, 2) && !$past(ackPulse);
  endproperty
  a_rd_ack: assert property (p_rd_ack)
    else $error("no ack before data");
  property p_wr_ack;
    s_wr_end and ackEnable |-> !ackPulse ##2 ackPulse;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("write ack misplaced");
  property p_resume;
    taken && debugActive && (cmdCode == DBRC_CMD_RESUME ||
      (cmdCode == DBRC_CMD_RESUME_UNTIL && !ackEnable))
      |=> !debugActive && cpuResume ##1 ackPulse == ackEnable;
  endproperty
  a_resume: assert property (p_resume)
    else $error("bad resume");
  property p_until;
    taken && debugActive && cmdCode == DBRC_CMD_RESUME_UNTIL && ackEnable
      |=> !debugActive && cpuResume ##1 !ackPulse;
  endproperty
  a_until: assert property (p_until)
    else $error("until acked early");
  property p_ack_len;
    $fell(ackPulse) |-> ackCnt == ACK_LEN;
  endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("ack length");
endmodule

bind dbrc_core dbrc_core_assertions #(.ADDR_W(ADDR_W), .ACK_LEN(ACK_LEN))
  dbrc_core_assertions_i (.*);

`default_nettype wire

// ---- dv/dbrc_mem_model.sv ----
// cpu side memory and register responder
`timescale 1ns/1ps
`default_nettype none

module dbrc_mem_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        abortOn,
  input  wire logic        memReq,
  input  wire logic [23:0] memAddr,
  input  wire logic        regReq,
  output logic             memDone,
  output logic             memAbort,
  output logic [31:0]      memRdata,
  output logic             regDone,
  output logic [31:0]      regRdata,
  output logic [3:0]       regByteValid
);
  logic [2:0] memCnt;
  logic       regCnt;

  // upper two register bytes unimplemented
  assign regByteValid = 4'b0011;

  //////////////////////////////////////////////////////////////////////////
  // data scrambles; valid only with done
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {memDone, memAbort, regDone, regCnt} <= 4'h0;
      memCnt   <= 3'h0;
      memRdata <= 32'h0000_0000;
      regRdata <= 32'h0000_0000;
    end
    else
    begin
      {memDone, memAbort, regDone, regCnt} <= 4'h0;
      memCnt   <= 3'h0;
      memRdata <= ~memRdata;
      regRdata <= ~regRdata;
      if (memReq && !memDone && !memAbort)
      begin
        memCnt <= memCnt + 3'h1;
        if (memCnt == (slow ? 3'h5 : 3'h0))
        begin
          memCnt   <= 3'h0;
          memDone  <= !abortOn;
          memAbort <= abortOn;
          memRdata <= {4{memAddr[7:0]}};
        end
      end
      if (regReq && !regDone)
      begin
        regCnt <= 1'b1;
        regDone <= regCnt;
        if (regCnt)
          regRdata <= 32'h1122_3344;
      end
    end
  end
endmodule

`default_nettype wire

// ---- dv/tb_dbrc_core.sv ----
// bench for the debug run control block
`timescale 1ns/1ps
`default_nettype none
`include "dbrc_consts.svh"

module tb_dbrc_core
  import dbrc_pkg::*;
  ;
  logic clk, rst, cmdValid, cmdWithStatus, syncReq, cmdReady, debugEnable;
  logic ackEnable, clearIllegal, debugActive, noResponse, illegalFlag;
  logic cpuInstrDone, cpuWaitMode, breakHalt, cpuResume, memReq, memWrite;
  logic memDone, memAbort, regReq, regDone, respValid, respHasData;
  logic respHasStatus, respStatusFirst, illegalResp, ackPulse, slow, abortOn;
  logic sawAck, sawRes, seenWr, ill, cpuStopMode;
  dbrc_cmd_type cmdCode;
  logic [1:0]   cmdSize, memSize;
  logic [23:0]  cmdAddr, memAddr, seenAddr;
  logic [31:0]  cmdWdata, memWdata, memRdata, regRdata, respData, seenData;
  logic [3:0]   regByteValid;
  logic [7:0]   respStatus;
  int           errorCnt, cmpCount;

  dbrc_core #(.ADDR_W(24), .ACK_LEN(4)) dbrc_core_i (.*);
  dbrc_mem_model dbrc_mem_model_i (.*);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // bus monitor
  always @(posedge clk)
  begin
    if (memReq)
      {seenWr, seenAddr, seenData} <= {memWrite, memAddr, memWdata};
    if (ackPulse)
      sawAck <= 1'b1;
    if (cpuResume)
      sawRes <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmpCount++;
    if (g !== e)
    begin
      errorCnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one command, held over its taking edge
  task automatic cmd(input dbrc_cmd_type c, input logic [1:0] s,
                     input logic ws, input logic [31:0] d);
    int n = 0;
    @(negedge clk);
    while (cmdReady !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 300)
    begin
      errorCnt++;
      testDone();
    end
    {cmdCode, cmdSize, cmdWithStatus, cmdWdata} = {c, s, ws, d};
    {sawAck, sawRes, cmdValid} = 3'b001;
    @(negedge clk);
    cmdValid = 1'b0;
  endtask

  // bounded answer wait
  task automatic waitResp(output logic il);
    int n = 0;
    while (respValid !== 1'b1 && illegalResp !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    il = illegalResp;
    if (n >= 300)
    begin
      errorCnt++;
      testDone();
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // block read checks
  task automatic rdBlk(input logic [1:0] s, logic ws, logic [23:0] a);
    cmd(DBRC_CMD_BLOCK_READ, s, ws, 32'h0000_0000);
    waitResp(ill);
    chk("rd refused", 0, ill);
    chk("rd addr", a, seenAddr);
    chk("rd data", a[7:0], respData[7:0]);
    chk("rd status", {ws, 1'b1}, {respHasStatus, respStatusFirst});
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    {cmdValid, cmdWithStatus, syncReq, debugEnable, ackEnable} = 5'h00;
    {clearIllegal, cpuInstrDone, cpuWaitMode, breakHalt, slow} = 5'h00;
    {abortOn, cpuStopMode, cmdSize, cmdAddr, cmdWdata} = '0;
    {errorCnt, cmpCount} = 64'h0;
    cmdCode = DBRC_CMD_NOP;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    cmd(DBRC_CMD_HALT, 0, 0, 0);
    pulse(cpuInstrDone);
    chk("halt disabled", 0, debugActive);
    foreach (cmdSize[i])
    begin
      cmd(i ? DBRC_CMD_RESUME : DBRC_CMD_REG_READ, 0, 0, 0);
      waitResp(ill);
      chk("inactive refused", 1, ill);
    end
    @(negedge clk);
    chk("illegal flag", 1, illegalFlag);
    pulse(clearIllegal);
    {debugEnable, cpuWaitMode} = 2'b11;
    cmd(DBRC_CMD_HALT, 0, 0, 0);
    repeat (16) @(negedge clk);
    chk("pending flags", 2'b01, {debugActive, noResponse});
    cmdAddr = 24'h00_0010;
    cmd(DBRC_CMD_READ_MEM, 0, 0, 0);
    rdBlk(0, 1, 24'h00_0011);
    chk("wait status", 3'b011, {respStatus[`DBRC_ST_ACTIVE],
        respStatus[`DBRC_ST_WAIT], respStatus[`DBRC_ST_NO_RESPONSE_FLAG]});
    rdBlk(1, 0, 24'h00_0012);
    rdBlk(2, 1, 24'h00_0014);
    cmd(DBRC_CMD_NOP, 0, 0, 0);
    ackEnable = 1'b1;
    rdBlk(0, 0, 24'h00_0018);
    chk("read ack", 1, sawAck);
    cpuWaitMode = 1'b0;
    pulse(cpuInstrDone);
    chk("halt entered", 1, debugActive);
    cmd(DBRC_CMD_BLOCK_WRITE, 0, 0, 0);
    waitResp(ill);
    chk("write after read", 1, ill);
    cmdAddr = 24'h00_0020;
    cmd(DBRC_CMD_WRITE_MEM, 1, 0, 0);
    slow = 1'b1;
    cmd(DBRC_CMD_BLOCK_WRITE, 2, 1, 32'hdead_beef);
    waitResp(ill);
    chk("wr addr", 24'h00_0022, seenAddr);
    chk("wr data", 32'hdead_beef, seenData);
    chk("wr status", 3'b110, {seenWr, respHasStatus, respStatusFirst});
    chk("wr ack", 1, sawAck);
    abortOn = 1'b1;
    cmd(DBRC_CMD_BLOCK_WRITE, 0, 0, 32'h0000_00a5);
    cmd(DBRC_CMD_BLOCK_READ, 0, 0, 0);
    chk("aborted addr", 24'h00_0026, seenAddr);
    waitResp(ill);
    chk("read after write", 1, ill);
    cmd(DBRC_CMD_REG_READ, 0, 0, 0);
    waitResp(ill);
    chk("reg data", 32'h0000_3344, respData);
    cmd(DBRC_CMD_RESUME, 0, 0, 0);
    repeat (3) @(negedge clk);
    chk("resume", 3'b011, {debugActive, sawRes, sawAck});
    pulse(breakHalt);
    cmd(DBRC_CMD_RESUME_UNTIL, 0, 0, 0);
    repeat (20) @(negedge clk);
    chk("until waits", 2'b00, {debugActive, sawAck});
    pulse(breakHalt);
    repeat (4) @(negedge clk);
    chk("until ack", 2'b11, {debugActive, sawAck});
    ackEnable = 1'b0;
    cmd(DBRC_CMD_RESUME_UNTIL, 0, 0, 0);
    repeat (3) @(negedge clk);
    chk("until no ack", 3'b010, {debugActive, sawRes, sawAck});
    pulse(breakHalt);
    ackEnable = 1'b1;
    cmd(DBRC_CMD_RESUME_UNTIL, 0, 0, 0);
    repeat (20) @(negedge clk);
    pulse(syncReq);
    chk("sync ends wait", 1, cmdReady);
    testDone();
  end
endmodule

`default_nettype wire
